/* common/psm_pkg.sv */
// shared constants, types and helpers of the printer stepper motor sequencer
// assumes a single 25 MHz system clock and a 32-bit classic wishbone bus
package psm_pkg;
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CYC_PER_MS_DEF = CLK_HZ / 1000;
  localparam int unsigned TW             = 18;
  localparam int unsigned ACC_STEPS      = 11;
  // step periods in microseconds, nominal value of the tolerance band
  localparam int unsigned PT_STD_US      = 2080;
  localparam int unsigned PT_COND_US     = 4160;
  // paper feed: steps and total time per line for each spacing
  localparam int unsigned PF_STEPS_6     = 36;
  localparam int unsigned PF_STEPS_8     = 27;
  localparam int unsigned PF_STEPS_9     = 24;
  localparam int unsigned PF_TIME_6_US   = 150_000;
  localparam int unsigned PF_TIME_8_US   = 113_000;
  localparam int unsigned PF_TIME_9_US   = 100_000;
  // register byte offsets
  localparam logic [4:0]  REG_CTRL       = 5'h00;
  localparam logic [4:0]  REG_STEPS      = 5'h04;
  localparam logic [4:0]  REG_STATUS     = 5'h08;
  // control register fields
  localparam int unsigned CTRL_CAR_GO    = 0;
  localparam int unsigned CTRL_DIR_RL    = 1;
  localparam int unsigned CTRL_COND      = 2;
  localparam int unsigned CTRL_PRINT_EN  = 3;
  localparam int unsigned CTRL_PAPER_GO  = 4;
  localparam int unsigned CTRL_SPC_LO    = 8;
  localparam logic [1:0]  SPC_6          = 2'h0;
  localparam logic [1:0]  SPC_8          = 2'h1;
  localparam logic [15:0] STEPS_RST      = 16'h0190;
  // phase patterns a,b,c,d in left-to-right order, a in the msb
  localparam logic [3:0]  PH0            = 4'h9;
  localparam logic [3:0]  PH1            = 4'ha;
  localparam logic [3:0]  PH2            = 4'h6;
  localparam logic [3:0]  PH3            = 4'h5;

  typedef enum logic [2:0] {C_IDLE, C_SEL, C_ACC, C_CONST, C_DEC, C_STOP} psm_car_t;
  typedef enum logic [1:0] {P_IDLE, P_SEL, P_RUN} psm_pap_t;

  function automatic logic [TW-1:0] psm_cyc(input longint us, input longint cpm,
                                             input longint steps);
    longint t;
    t = (us * cpm) / (longint'(1000) * steps);
    return TW'(t);
  endfunction

  function automatic logic [3:0] psm_pat(input logic [1:0] idx);
    case (idx)
      2'h0:    return PH0;
      2'h1:    return PH1;
      2'h2:    return PH2;
      default: return PH3;
    endcase
  endfunction

  // right-to-left and paper feed walk the same ring backwards
  function automatic logic [1:0] psm_nxt(input logic [1:0] idx, input logic back);
    return back ? idx - 2'h1 : idx + 2'h1;
  endfunction
endpackage

/* design/psm_top.sv */
// printer stepper motor sequencer: closed-loop carriage and open-loop paper feed
// assumes all inputs synchronous to MCLK_I and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none
module psm_top
  import psm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
  input  wire logic        MCLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [4:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        ENCODER_PEAK_VELOCITY_PULSE_I,
  input  wire logic        HOME_REFERENCE_I,
  output logic      [3:0]  CAR_PHASE_O,
  output logic      [3:0]  PAPER_PHASE_O,
  output logic             CARRIAGE_SELECT_STANDARD_O,
  output logic             CARRIAGE_SELECT_CONDENSED_O,
  output logic             PAPER_MOTOR_SELECT_O,
  output logic             PRINT_PERMIT_O
);
  localparam logic [TW-1:0] PT_STD_CYC  = psm_cyc(PT_STD_US, CYC_PER_MS, 1);
  localparam logic [TW-1:0] PT_COND_CYC = psm_cyc(PT_COND_US, CYC_PER_MS, 1);
  localparam logic [TW-1:0] PF_6_CYC    = psm_cyc(PF_TIME_6_US, CYC_PER_MS, PF_STEPS_6);
  localparam logic [TW-1:0] PF_8_CYC    = psm_cyc(PF_TIME_8_US, CYC_PER_MS, PF_STEPS_8);
  localparam logic [TW-1:0] PF_9_CYC    = psm_cyc(PF_TIME_9_US, CYC_PER_MS, PF_STEPS_9);
  localparam logic [3:0]    ACC_LAST    = 4'(ACC_STEPS - 1);

  typedef struct packed {
    logic                         ack;
    logic [31:0]                  rdat;
    logic                         dir_rl;
    logic                         cond;
    logic                         print_en;
    logic [1:0]                   spacing;
    logic [15:0]                  nsteps;
    psm_car_t                     cst;
    psm_pap_t                     pst;
    logic [1:0]                   cidx;
    logic [1:0]                   pidx;
    logic [3:0]                   cph;
    logic [3:0]                   pph;
    logic                         sel_std;
    logic                         sel_cond;
    logic                         psel;
    logic [TW-1:0]                tmr;
    logic [TW-1:0]                ptmr;
    logic [15:0]                  cnt;
    logic [3:0]                   acnt;
    logic [5:0]                   pcnt;
    logic                         peak_seen;
    logic                         enc_q;
    logic                         enc_prev;
    logic                         home_q;
    logic                         print_ok;
    logic [ACC_STEPS-1:0][TW-1:0] tbl;
  } psm_state_t;

  psm_state_t s_q;
  psm_state_t s_d;

  logic          bus_req;
  logic          car_go;
  logic          pap_go;
  logic          peak_edge;
  logic          car_step;
  logic          pt_done;
  logic [TW-1:0] pt_cyc;
  logic [TW-1:0] pf_cyc;
  logic [5:0]    pf_steps;

  always_comb begin
    s_d       = s_q;
    bus_req   = WB_CYC_I && WB_STB_I && !s_q.ack;
    car_go    = 1'b0;
    pap_go    = 1'b0;
    car_step  = 1'b0;
    // encoder pin is registered twice, a rising edge marks the peak velocity point
    s_d.enc_q    = ENCODER_PEAK_VELOCITY_PULSE_I;
    s_d.enc_prev = s_q.enc_q;
    s_d.home_q   = HOME_REFERENCE_I;
    peak_edge    = s_q.enc_q && !s_q.enc_prev;

    pt_cyc = s_q.cond ? PT_COND_CYC : PT_STD_CYC;
    case (s_q.spacing)
      SPC_6: begin
        pf_cyc   = PF_6_CYC;
        pf_steps = 6'(PF_STEPS_6);
      end
      SPC_8: begin
        pf_cyc   = PF_8_CYC;
        pf_steps = 6'(PF_STEPS_8);
      end
      default: begin
        pf_cyc   = PF_9_CYC;
        pf_steps = 6'(PF_STEPS_9);
      end
    endcase

    // wishbone slave: one wait state, every address answered
    s_d.ack = bus_req;
    if (bus_req) begin
      s_d.rdat = 32'h0000_0000;
      if (WB_WE_I) begin
        if (WB_ADR_I == REG_CTRL) begin
          if (WB_SEL_I[0]) begin
            car_go       = WB_DAT_I[CTRL_CAR_GO];
            pap_go       = WB_DAT_I[CTRL_PAPER_GO];
            s_d.print_en = WB_DAT_I[CTRL_PRINT_EN];
            // direction and mode are only taken while the carriage rests
            if (s_q.cst == C_IDLE) begin
              s_d.dir_rl = WB_DAT_I[CTRL_DIR_RL];
              s_d.cond   = WB_DAT_I[CTRL_COND];
            end
          end
          if (WB_SEL_I[1] && s_q.pst == P_IDLE) begin
            s_d.spacing = WB_DAT_I[CTRL_SPC_LO +: 2];
          end
        end else if (WB_ADR_I == REG_STEPS && s_q.cst == C_IDLE) begin
          if (WB_SEL_I[0]) begin
            s_d.nsteps[7:0] = WB_DAT_I[7:0];
          end
          if (WB_SEL_I[1]) begin
            s_d.nsteps[15:8] = WB_DAT_I[15:8];
          end
        end
      end else begin
        case (WB_ADR_I)
          REG_CTRL: begin
            s_d.rdat[CTRL_DIR_RL]        = s_q.dir_rl;
            s_d.rdat[CTRL_COND]          = s_q.cond;
            s_d.rdat[CTRL_PRINT_EN]      = s_q.print_en;
            s_d.rdat[CTRL_SPC_LO +: 2]   = s_q.spacing;
          end
          REG_STEPS: begin
            s_d.rdat[15:0] = s_q.nsteps;
          end
          REG_STATUS: begin
            s_d.rdat[0]     = s_q.cst != C_IDLE;
            s_d.rdat[1]     = s_q.pst != P_IDLE;
            s_d.rdat[2]     = s_q.print_ok;
            s_d.rdat[3]     = s_q.home_q;
            s_d.rdat[6:4]   = s_q.cst;
            s_d.rdat[11:8]  = s_q.cph;
            s_d.rdat[15:12] = s_q.pph;
          end
          default: begin
            s_d.rdat = 32'h0000_0000;
          end
        endcase
      end
    end

    // carriage: closed loop, an acceleration or constant-speed step needs both the step time and the peak pulse
    if (peak_edge) begin
      s_d.peak_seen = 1'b1;
    end
    if (s_q.tmr != {TW{1'b1}}) begin
      s_d.tmr = s_q.tmr + TW'(1);
    end
    pt_done = s_q.tmr >= pt_cyc - TW'(1);
    case (s_q.cst)
      C_IDLE: begin
        // software places the carriage at physical home before a go
        if (car_go) begin
          s_d.sel_std  = !s_q.cond;
          s_d.sel_cond = s_q.cond;
          s_d.cph      = psm_pat(s_q.cidx);
          s_d.cst      = C_SEL;
        end
      end
      C_SEL: begin
        // rush current is on for one clock before the first phase change
        car_step = 1'b1;
        s_d.acnt = 4'h0;
        s_d.cst  = C_ACC;
      end
      C_ACC: begin
        if (pt_done && (s_q.peak_seen || peak_edge)) begin
          car_step          = 1'b1;
          s_d.tbl[s_q.acnt] = s_q.tmr + TW'(1);
          s_d.acnt          = s_q.acnt + 4'h1;
          if (s_q.acnt == ACC_LAST) begin
            s_d.cnt = s_q.nsteps;
            s_d.cst = C_CONST;
          end
        end
      end
      C_CONST: begin
        // an early peak pulse waits for the step time; a late one still gates
        if (pt_done && (s_q.peak_seen || peak_edge)) begin
          car_step = 1'b1;
          if (s_q.cnt == 16'h0000) begin
            s_d.acnt = ACC_LAST;
            s_d.cst  = C_DEC;
          end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
          end
        end
      end
      C_DEC: begin
        if (s_q.tmr >= s_q.tbl[s_q.acnt] - TW'(1)) begin
          car_step = 1'b1;
          if (s_q.acnt == 4'h0) begin
            s_d.cst = C_STOP;
          end else begin
            s_d.acnt = s_q.acnt - 4'h1;
          end
        end
      end
      C_STOP: begin
        // last step was issued one clock ago; drop back to hold current
        s_d.sel_std  = 1'b0;
        s_d.sel_cond = 1'b0;
        s_d.cst      = C_IDLE;
      end
      default: begin
        s_d.cst = C_IDLE;
      end
    endcase
    if (car_step) begin
      s_d.cidx      = psm_nxt(s_q.cidx, s_q.dir_rl);
      s_d.cph       = psm_pat(psm_nxt(s_q.cidx, s_q.dir_rl));
      s_d.tmr       = {TW{1'b0}};
      s_d.peak_seen = 1'b0;
    end
    s_d.print_ok = (s_d.cst == C_CONST) && s_d.print_en;

    // paper feed: open loop, fixed period, no sensor involved
    case (s_q.pst)
      P_IDLE: begin
        if (pap_go) begin
          s_d.psel = 1'b1;
          s_d.pph  = psm_pat(s_q.pidx);
          s_d.pst  = P_SEL;
        end
      end
      P_SEL: begin
        s_d.pidx = psm_nxt(s_q.pidx, 1'b1);
        s_d.pph  = psm_pat(psm_nxt(s_q.pidx, 1'b1));
        s_d.pcnt = pf_steps - 6'h01;
        s_d.ptmr = {TW{1'b0}};
        s_d.pst  = P_RUN;
      end
      P_RUN: begin
        s_d.ptmr = s_q.ptmr + TW'(1);
        if (s_q.ptmr >= pf_cyc - TW'(1)) begin
          s_d.ptmr = {TW{1'b0}};
          if (s_q.pcnt == 6'h00) begin
            s_d.psel = 1'b0;
            s_d.pst  = P_IDLE;
          end else begin
            s_d.pcnt = s_q.pcnt - 6'h01;
            s_d.pidx = psm_nxt(s_q.pidx, 1'b1);
            s_d.pph  = psm_pat(psm_nxt(s_q.pidx, 1'b1));
          end
        end
      end
      default: begin
        s_d.pst = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      s_q        <= '0;
      s_q.nsteps <= STEPS_RST;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  assign WB_DAT_O                    = s_q.rdat;
  assign WB_ACK_O                    = s_q.ack;
  assign CAR_PHASE_O                 = s_q.cph;
  assign PAPER_PHASE_O               = s_q.pph;
  assign CARRIAGE_SELECT_STANDARD_O  = s_q.sel_std;
  assign CARRIAGE_SELECT_CONDENSED_O = s_q.sel_cond;
  assign PAPER_MOTOR_SELECT_O        = s_q.psel;
  assign PRINT_PERMIT_O              = s_q.print_ok;
endmodule // psm_top
`default_nettype wire

/* testbench/psm_top_sva.sv */
// port assertions for the stepper motor sequencer
// assumes it is bound to psm_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module psm_top_sva
  import psm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
  input wire logic       MCLK_I,
  input wire logic       RSTN_I,
  input wire logic       CE_I,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_ACK_O,
  input wire logic [3:0] CAR_PHASE_O,
  input wire logic [3:0] PAPER_PHASE_O,
  input wire logic       CARRIAGE_SELECT_STANDARD_O,
  input wire logic       CARRIAGE_SELECT_CONDENSED_O,
  input wire logic       PAPER_MOTOR_SELECT_O,
  input wire logic       PRINT_PERMIT_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  logic car_sel;
  assign car_sel = CARRIAGE_SELECT_STANDARD_O | CARRIAGE_SELECT_CONDENSED_O;
  function automatic logic [3:0] ring(input logic [3:0] p, input logic back);
    case (p)
      PH0:     return back ? PH3 : PH1;
      PH1:     return back ? PH0 : PH2;
      PH2:     return back ? PH1 : PH3;
      default: return back ? PH2 : PH0;
    endcase
  endfunction
  ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CE_I |=> WB_ACK_O)
    else $error("bus request not acknowledged");
  sel_excl_a: assert property (!(CARRIAGE_SELECT_STANDARD_O && CARRIAGE_SELECT_CONDENSED_O))
    else $error("both carriage selects high");
  permit_sel_a: assert property (PRINT_PERMIT_O |-> car_sel)
    else $error("print permit without moving carriage");
  car_ring_a: assert property (($changed(CAR_PHASE_O) && $past(CAR_PHASE_O) != 4'h0)
    |-> (CAR_PHASE_O == ring($past(CAR_PHASE_O), 1'b0)
      || CAR_PHASE_O == ring($past(CAR_PHASE_O), 1'b1))) else $error("carriage step skipped");
  pap_ring_a: assert property (($changed(PAPER_PHASE_O) && $past(PAPER_PHASE_O) != 4'h0)
    |-> PAPER_PHASE_O == ring($past(PAPER_PHASE_O), 1'b1)) else $error("paper step wrong");
  car_rush_a: assert property (($changed(CAR_PHASE_O) && $past(CAR_PHASE_O) != 4'h0)
    |-> $past(car_sel)) else $error("carriage stepped in hold current");
  pap_rush_a: assert property (($changed(PAPER_PHASE_O) && $past(PAPER_PHASE_O) != 4'h0)
    |-> $past(PAPER_MOTOR_SELECT_O)) else $error("paper stepped in hold current");
  reset_idle_a: assert property (disable iff (1'b0) !RSTN_I |=>
    (CAR_PHASE_O == 4'h0 && PAPER_PHASE_O == 4'h0 && !car_sel && !PAPER_MOTOR_SELECT_O
      && !PRINT_PERMIT_O)) else $error("outputs active after reset");
endmodule // psm_top_sva
`default_nettype wire

/* testbench/psm_motor_model.sv */
// encoder and home sensor model of the carriage mechanism
// assumes carriage phases and selects come straight from the sequencer
`timescale 1ns/1ps
`default_nettype none
module psm_motor_model
  import psm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] car_phase_i,
  input  wire logic       sel_std_i,
  input  wire logic       sel_cond_i,
  output logic            peak_o,
  output logic            home_o
);
  logic [3:0] last_q = 4'h0;
  logic       peak_q = 1'b0;
  int         pos_q = 0;
  int         nstep_q = 0;
  int         dly_q = 0;
  function automatic int idx(input logic [3:0] p);
    return (p == PH0) ? 0 : (p == PH1) ? 1 : (p == PH2) ? 2 : 3;
  endfunction
  always @(posedge clk_i) begin
    peak_q <= 1'b0;
    if (!rst_n_i) begin
      pos_q <= 0;
      dly_q <= 0;
    end else if (car_phase_i != last_q && last_q != 4'h0) begin
      pos_q <= pos_q + (((idx(car_phase_i) - idx(last_q) + 4) % 4 == 1) ? 1 : -1);
      nstep_q <= nstep_q + 1;
      // rotor lags the step time early in the move, leads it once up to speed
      dly_q <= (nstep_q < 6) ? (sel_cond_i ? 60 : 30) : 5;
    end else if (dly_q > 0) begin
      dly_q <= dly_q - 1;
      peak_q <= (dly_q == 1);
    end
    if (!(sel_std_i || sel_cond_i))
      nstep_q <= 0;
    last_q <= car_phase_i;
  end
  assign peak_o = peak_q;
  assign home_o = (pos_q == 0);
endmodule // psm_motor_model
`default_nettype wire

/* testbench/tb_psm_top.sv */
// self-checking bench of the stepper motor sequencer
// assumes psm_top, its checker and the motor model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_psm_top;
  import psm_pkg::*;
  localparam int unsigned CPM = 10;
  typedef struct packed {logic rd; logic [31:0] exp; logic [31:0] msk;} psm_rd_t;
  typedef struct {int n; logic back; logic pe; logic cond; int per;} psm_mv_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_we = 1'b0;
  logic [4:0] wb_adr = 5'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] seed = 32'hb9301d87;
  wire logic [31:0] wb_rdat;
  wire logic [3:0] car_ph, pap_ph;
  wire logic wb_ack, sel_std, sel_cond, sel_pap, permit, peak, home;
  psm_rd_t rd_q[$];
  psm_mv_t car_q[$], pap_q[$];
  int n_mismatch = 0, samples_checked = 0, car_cnt = 0, pap_cnt = 0, car_n = 0, pap_n = 0;
  int acc_t[$];
  logic [3:0] car_l = 4'h0, pap_l = 4'h0;
  logic car_s = 1'b0, pap_s = 1'b0, perm_l = 1'b0, perm_seen = 1'b0;
  always #20 clk = ~clk;
  psm_top #(.CYC_PER_MS(CPM)) uut (.MCLK_I(clk), .RSTN_I(rst_n), .CE_I(1'b1),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_cyc), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .ENCODER_PEAK_VELOCITY_PULSE_I(peak), .HOME_REFERENCE_I(home), .CAR_PHASE_O(car_ph),
    .PAPER_PHASE_O(pap_ph), .CARRIAGE_SELECT_STANDARD_O(sel_std),
    .CARRIAGE_SELECT_CONDENSED_O(sel_cond), .PAPER_MOTOR_SELECT_O(sel_pap),
    .PRINT_PERMIT_O(permit));
  psm_motor_model u_mot (.clk_i(clk), .rst_n_i(rst_n), .car_phase_i(car_ph),
    .sel_std_i(sel_std), .sel_cond_i(sel_cond), .peak_o(peak), .home_o(home));
  function automatic logic [3:0] ring(input logic [3:0] p, input logic back);
    case (p)
      PH0:     return back ? PH3 : PH1;
      PH1:     return back ? PH0 : PH2;
      PH2:     return back ? PH1 : PH3;
      default: return back ? PH2 : PH0;
    endcase
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one compare per kind of result: bus read data, phase pattern, counted value
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp, "read data");
  endtask
  task automatic chk_ph(input logic [3:0] got, input logic [3:0] exp, input string what);
    chk(32'(got), 32'(exp), what);
  endtask
  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp, input string what);
    chk(got, exp, what);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back('{!w, e, m});
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic car(input logic back, input logic cond, input logic pe, input int s);
    logic [31:0] c;
    c = {28'h0, pe, cond, back, 1'b0};
    wb(1'b1, REG_STEPS, 32'(s), 32'h0, 32'h0);
    wb(1'b1, REG_CTRL, c, 32'h0, 32'h0);
    car_q.push_back('{s + 2 + 2 * ACC_STEPS, back, pe, cond,
                      (cond ? PT_COND_US : PT_STD_US) * CPM / 1000});
    wb(1'b1, REG_CTRL, c | 32'h1, 32'h0, 32'h0);
    while (car_q.size() > 0) @(posedge clk);
  endtask
  task automatic pap(input int k);
    int n;
    int t;
    n = (k == 0) ? PF_STEPS_6 : (k == 1) ? PF_STEPS_8 : PF_STEPS_9;
    t = (k == 0) ? PF_TIME_6_US : (k == 1) ? PF_TIME_8_US : PF_TIME_9_US;
    wb(1'b1, REG_CTRL, 32'(k) << CTRL_SPC_LO, 32'h0, 32'h0);
    pap_q.push_back('{n, 1'b1, 1'b0, 1'b0, t * CPM / (1000 * n)});
    wb(1'b1, REG_CTRL, (32'(k) << CTRL_SPC_LO) | 32'h10, 32'h0, 32'h0);
    while (pap_q.size() > 0) @(posedge clk);
  endtask
  always @(posedge clk) begin
    psm_rd_t r;
    car_cnt++;
    pap_cnt++;
    if (wb_ack === 1'b1 && rd_q.size() > 0) begin
      r = rd_q.pop_front();
      if (r.rd) chk_rd(wb_rdat & r.msk, r.exp);
    end
    if (car_q.size() > 0) begin
      if (!car_s && (sel_std || sel_cond))
        chk_num({sel_std, sel_cond}, car_q[0].cond ? 2'b01 : 2'b10, "select");
      if (car_ph !== car_l && car_l != 4'h0) begin
        car_n++;
        chk_ph(car_ph, ring(car_l, car_q[0].back), "carriage step");
        if (permit === 1'b1 && perm_l) chk_num(car_cnt, car_q[0].per, "speed");
        if (permit === 1'b1 && !perm_l && car_q[0].pe)
          chk_num(car_n, 1 + ACC_STEPS, "accel steps");
        // step 1 leaves rest; the next eleven intervals are the acceleration profile
        if (car_n > 1 && car_n <= 1 + int'(ACC_STEPS)) acc_t.push_back(car_cnt);
        if (car_n > car_q[0].n - int'(ACC_STEPS) && acc_t.size() > 0)
          chk_num(car_cnt, acc_t.pop_back(), "decel period");
        car_cnt = 0;
        perm_l = (permit === 1'b1);
      end
      perm_seen |= (permit === 1'b1);
      if (car_s && !(sel_std || sel_cond)) begin
        chk_num(car_n, car_q[0].n, "carriage steps");
        chk_num(perm_seen, car_q[0].pe, "print permit");
        void'(car_q.pop_front());
        acc_t.delete();
        car_n = 0;
        perm_seen = 1'b0;
      end
    end
    if (pap_q.size() > 0) begin
      if (pap_ph !== pap_l && pap_l != 4'h0) begin
        pap_n++;
        chk_ph(pap_ph, ring(pap_l, 1'b1), "paper step");
        if (pap_n > 1) chk_num(pap_cnt, pap_q[0].per, "paper rate");
        pap_cnt = 0;
      end
      if (pap_s && !sel_pap) begin
        chk_num(pap_n, pap_q[0].n, "paper steps");
        void'(pap_q.pop_front());
        pap_n = 0;
      end
    end
    car_s = sel_std || sel_cond;
    pap_s = sel_pap;
    car_l = car_ph;
    pap_l = pap_ph;
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED %0t timeout", $time);
    wrap_up();
  end
  initial begin
    int s;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, REG_STATUS, 32'h0, 32'h8, 32'hffffffff);
    wb(1'b0, REG_STEPS, 32'h0, {16'h0, STEPS_RST}, 32'hffffffff);
    // unmapped place: write must vanish, read gives zero
    wb(1'b1, 5'h0c, 32'hffffffff, 32'h0, 32'h0);
    wb(1'b0, 5'h0c, 32'h0, 32'h0, 32'hffffffff);
    seed = xs(seed);
    s = 2 + int'(seed[1:0]);
    car(1'b0, 1'b0, 1'b1, s);
    car(1'b1, 1'b1, 1'b1, s);
    wb(1'b0, REG_STATUS, 32'h0, 32'h8, 32'hf);
    wb(1'b0, REG_CTRL, 32'h0, 32'he, 32'hffffffff);
    seed = xs(seed);
    car(1'b0, 1'b0, 1'b0, 2 + int'(seed[1:0]));
    for (int k = 0; k < 4; k++)
      pap(k);
    wrap_up();
  end
endmodule // tb_psm_top
bind psm_top psm_top_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
  .CE_I(CE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .CAR_PHASE_O(CAR_PHASE_O), .PAPER_PHASE_O(PAPER_PHASE_O),
  .CARRIAGE_SELECT_STANDARD_O(CARRIAGE_SELECT_STANDARD_O),
  .CARRIAGE_SELECT_CONDENSED_O(CARRIAGE_SELECT_CONDENSED_O),
  .PAPER_MOTOR_SELECT_O(PAPER_MOTOR_SELECT_O), .PRINT_PERMIT_O(PRINT_PERMIT_O));
`default_nettype wire
